// *** bench/msd_top_monitor.sv ***
// Purpose: checker for msd_top next-address and address forming
// Assumes: run bit mirrored from control writes
// Notes: bound to every msd_top instance
`timescale 1ns/1ps
`default_nettype none
module msd_top_monitor #(
	parameter UAW = 11,
	parameter SPW = 6,
	parameter WW = 36
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [UAW-1:0] uword_jump,
	input wire logic [SPW-1:0] special_dispatch_select,
	input wire logic next_instruction_condition,
	input wire logic trap_pending,
	input wire logic [WW-1:0] index_register,
	input wire logic [3:0] index_select,
	input wire logic [UAW-1:0] next_microaddress,
	input wire logic [WW-1:0] effective_address,
	input wire logic [WW-1:0] arithmetic_register,
	input wire logic compute_address_flag
);
	logic run_ff;
	logic home;
	logic act;
	logic [5:0] sp;
	assign sp = special_dispatch_select;
	assign home = run_ff && next_microaddress == 11'h060;
	assign act = run_ff && next_microaddress != 11'h060;
	// run is internal, so follow it from control writes
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
			run_ff <= 1'b0;
		else if (reg_wr && reg_addr == 8'h00)
			run_ff <= reg_wdata[0];
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_start_home: assert property ($past(rst) |-> next_microaddress == 11'h060) else $error("bad start");
	chk_normal_entry: assert property (home && !trap_pending && next_instruction_condition
		|=> next_microaddress == 11'h06A) else $error("bad entry");
	chk_trap_entry: assert property (home && trap_pending |=> next_microaddress == 11'h062) else $error("bad trap");
	chk_mode_or: assert property (act && sp == 6'h1E
		|=> next_microaddress[10:2] == $past(uword_jump[10:2])
		&& next_microaddress[0] == ($past(uword_jump[0]) | (|$past(index_select))) && compute_address_flag)
		else $error("bad mode");
	chk_operand_base: assert property (act && sp == 6'h07 && compute_address_flag
		|=> next_microaddress[10:4] == 7'h02 && !compute_address_flag) else $error("bad operand");
	chk_store_or: assert property (act && sp == 6'h1B
		|=> next_microaddress[10:4] == $past(uword_jump[10:4])
		&& (next_microaddress[3:0] | $past(uword_jump[3:0])) == next_microaddress[3:0]) else $error("bad store");
	chk_plain_jump: assert property (act && !(sp inside {6'h1E, 6'h1B, 6'h07, 6'h01})
		|=> next_microaddress == $past(uword_jump)) else $error("bad jump");
	chk_index_sum: assert property (|index_select
		|=> effective_address == $past(arithmetic_register) + $past(index_register)) else $error("bad sum");
	cover property (home && next_instruction_condition);
	cover property (act && sp == 6'h1E && |index_select);
	cover property (act && sp == 6'h07 && compute_address_flag);
endmodule
bind msd_top msd_top_monitor #(.UAW(UAW), .SPW(SPW), .WW(WW)) u_mon (.clk_sys, .rst, .reg_addr, .reg_wdata,
	.reg_wr, .uword_jump, .special_dispatch_select, .next_instruction_condition, .trap_pending, .index_register,
	.index_select, .next_microaddress, .effective_address, .arithmetic_register, .compute_address_flag);
`default_nettype wire

// *** bench/msd_top_tb.sv ***
// Purpose: self-checking bench for msd_top
// Assumes: 40 MHz clock, async high reset
// Notes: random instructions and map words from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module msd_top_tb;
	logic clk_sys = 0;
	logic rst = 1;
	logic [7:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [10:0] uword_jump = 0;
	logic [5:0] special_dispatch_select = 0;
	logic next_instruction_condition = 0;
	logic trap_pending = 0;
	logic fetch_valid = 0;
	logic [35:0] fetch_data = 0;
	logic [35:0] index_register = 0;
	wire [31:0] reg_rdata;
	wire [3:0] index_select;
	wire [10:0] next_microaddress;
	wire [35:0] effective_address;
	wire [35:0] arithmetic_register;
	wire compute_address_flag;
	int failures = 0;
	int checks = 0;
	logic [35:0] ins;
	logic [23:0] mw;
	logic [10:0] j;
	logic [5:0] s;
	always #12.5 clk_sys = ~clk_sys;
	msd_top dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .uword_jump,
		.special_dispatch_select, .next_instruction_condition, .trap_pending, .fetch_valid, .fetch_data,
		.index_register, .index_select, .next_microaddress, .effective_address, .arithmetic_register,
		.compute_address_flag);
	task test_done;
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task cmp(input logic [35:0] g, input logic [35:0] e);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// drives land 1 ns after the edge so no race with the sampling edge
	task tick;
		@(posedge clk_sys);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		tick;
		reg_wr <= 1'b0;
		// an idle edge so the next call never reassigns a strobe in this step
		tick;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		tick;
		reg_rd <= 1'b0;
		cmp(reg_rdata, e);
		tick;
	endtask
	task st(input logic [10:0] jj, input logic [5:0] ss, input logic [10:0] e);
		uword_jump <= jj;
		special_dispatch_select <= ss;
		tick;
		cmp(next_microaddress, e);
	endtask
	initial
	begin
		void'($urandom(46744));
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		tick;
		rd(8'h0C, 32'h060);
		rd(8'h20, 32'h0);
		wr(8'h00, 32'h1);
		trap_pending <= 1'b1;
		st(11'h7FF, 6'h00, 11'h062);
		trap_pending <= 1'b0;
		st(11'h060, 6'h06, 11'h060);
		st(11'h7FF, 6'h1E, 11'h060);
		cmp(compute_address_flag, 1'b0);
		repeat (20)
		begin
			ins = {$urandom, 4'h5};
			mw = 24'($urandom);
			// map jump kept away from the decision address
			mw[10] = 1'b1;
			j = 11'h400 | 11'($urandom);
			index_register <= {$urandom, 4'hA};
			wr(8'h04, {23'h0, ins[35:27]});
			wr(8'h08, {8'h0, mw});
			fetch_data <= ins;
			fetch_valid <= 1'b1;
			st(11'h000, 6'h00, 11'h060);
			fetch_valid <= 1'b0;
			next_instruction_condition <= 1'b1;
			st(11'h000, 6'h00, 11'h06A);
			next_instruction_condition <= 1'b0;
			cmp(index_select, ins[21:18]);
			st(j, 6'h1E, j | {ins[22], |ins[21:18]});
			cmp(compute_address_flag, 1'b1);
			cmp(arithmetic_register, {{18{ins[17]}}, ins[17:0]});
			st(j, 6'h07, 11'h020 | mw[19:16]);
			cmp(effective_address, {{18{ins[17]}}, ins[17:0]} + (|ins[21:18] ? index_register : 36'h0));
			st(11'h000, 6'h01, mw[10:0]);
			st(j, 6'h1B, j | mw[23:20]);
			st(j, 6'h07, j | mw[19:16]);
			s = 6'($urandom);
			if (s inside {6'h1E, 6'h1B, 6'h07, 6'h01})
				s = 6'h00;
			st(j, s, j);
			st(11'h060, 6'h06, 11'h060);
		end
		test_done;
	end
	initial
	begin
		#(25 * 2000);
		failures++;
		test_done;
	end
endmodule
`default_nettype wire

// *** logic/msd_ea_adder.v ***
// Purpose: effective address adder
// Assumes: index register contents supplied by fast memory on the same clock
// Notes: result registered; index 0 means no indexing
`timescale 1ns/1ps
`default_nettype none
module msd_ea_adder #(
	parameter W = 36
) (
	input wire clk_sys,
	input wire rst,
	input wire indexed,
	input wire [W-1:0] arith,
	input wire [W-1:0] index_data,
	output reg [W-1:0] ea_ff
);
	wire [W-1:0] nxt_ea;

	assign nxt_ea = indexed ? arith + index_data : arith;

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			ea_ff <= {W{1'b0}};
		else
			ea_ff <= nxt_ea;
	end
endmodule
`default_nettype wire

// *** logic/msd_map_mem.v ***
// Purpose: per-opcode dispatch map storage
// Assumes: one write port, one read port, read data registered
// Notes: contents are undefined until software loads them
`timescale 1ns/1ps
`default_nettype none
module msd_map_mem #(
	parameter AW = 9,
	parameter DW = 24
) (
	input wire clk_sys,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge clk_sys)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// *** logic/msd_regs.vh ***
// Purpose: constants for the microsequencer dispatch block
// Assumes: 11-bit microaddress, 6-bit special dispatch field, 36-bit words
// Notes: microaddresses are octal in the microcode, written here in hex
`ifndef MSD_REGS_VH
`define MSD_REGS_VH

// special dispatch select codes (octal 36, 33, 06, 01, 07)
`define MSD_SPECIAL_DISPATCH_SELECT_ADDR_MODE 6'h1E
`define MSD_SPECIAL_DISPATCH_SELECT_STORE 6'h1B
`define MSD_SPECIAL_DISPATCH_SELECT_NEXT_INSTR 6'h06
`define MSD_SPECIAL_DISPATCH_SELECT_MAP_JUMP 6'h01
`define MSD_SPECIAL_DISPATCH_SELECT_OPERAND_READ 6'h07

// fixed microaddresses: decision start (octal 140), offsets within it
`define MSD_UA_NEXT 11'h060
`define MSD_NI_OFS_NORMAL 11'h00A
`define MSD_NI_OFS_TRAP 11'h002
`define MSD_UA_EXEC_ENTRY 11'h06A
// forced operand-read base (octal 40)
`define MSD_UA_OPERAND_BASE 11'h020

// instruction word bit positions (bit 35 is the msb of the 36-bit word)
`define MSD_INSTR_OP_HI 35
`define MSD_INSTR_OP_LO 27
`define MSD_INSTR_INDIRECT 22
`define MSD_INSTR_INDEX_HI 21
`define MSD_INSTR_INDEX_LO 18
`define MSD_INSTR_Y_HI 17

// dispatch map word fields in a 32-bit bus word
`define MSD_MAP_J_HI 10
`define MSD_MAP_J_LO 0
`define MSD_MAP_A_HI 19
`define MSD_MAP_A_LO 16
`define MSD_MAP_B_HI 23
`define MSD_MAP_B_LO 20
`define MSD_MAP_W 24

// register byte offsets
`define MSD_REG_CTRL 8'h00
`define MSD_REG_MAP_ADDR 8'h04
`define MSD_REG_MAP_DATA 8'h08
`define MSD_REG_STATUS 8'h0C
`define MSD_REG_EA 8'h10
`define MSD_REG_HOLD 8'h14

// control register bits and reset value
`define MSD_CTRL_RUN 0
`define MSD_CTRL_RESET 1'b0

`endif

// *** logic/msd_top.v ***
// Purpose: next-microaddress selection, dispatch and effective address forming
// Assumes: control store outside, addressed by next_microaddress; all inputs on clk_sys
// Notes: software loads the dispatch map and enables sequencing over the register port
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "msd_regs.vh"

// Notes on behaviour
// - The microword jump field is the proposed next microaddress, altered only by the selected dispatch; it is ignored at 140 and while run is clear.
// - The next-instruction decision starts at microaddress 140 and picks trap or normal entry.
// - In the normal case execution begins from the instruction already in the hold register.
// - Special dispatch code 36 selects the address mode dispatch.
// - The address mode dispatch ORs the indexing (bits 14-17) and indirection (bit 13) conditions into the jump field.
// - Code 33 ORs the map word B field into the jump field.
// - Code 06 passes the jump field through unaltered and clears the address computation flag.
// - An operand read after an address computation forces octal 40 and ORs in the map word A field.
// - Code 01 takes the next microaddress from the map word jump field.
// - With indexing the effective address is arithmetic register plus index register.
module msd_top #(
	parameter UAW = 11,
	parameter SPW = 6,
	parameter WW = 36,
	parameter OPW = 9
) (
	input wire clk_sys,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire [UAW-1:0] uword_jump,
	input wire [SPW-1:0] special_dispatch_select,
	input wire next_instruction_condition,
	input wire trap_pending,
	input wire fetch_valid,
	input wire [WW-1:0] fetch_data,
	input wire [WW-1:0] index_register,
	output wire [3:0] index_select,
	output wire [UAW-1:0] next_microaddress,
	output wire [WW-1:0] effective_address,
	output wire [WW-1:0] arithmetic_register,
	output wire compute_address_flag
);
	reg run_ff;
	reg [OPW-1:0] map_addr_ff;
	reg [UAW-1:0] upc_ff;
	reg [UAW-1:0] nxt_upc;
	reg [WW-1:0] instruction_hold_register_ff;
	reg [WW-1:0] arith_ff;
	reg [WW-1:0] nxt_arith;
	reg compute_address_flag_ff;
	reg nxt_compute_address_flag;
	reg [31:0] nxt_rdata;
	wire map_wr;
	wire [`MSD_MAP_W-1:0] map_word;
	wire [UAW-1:0] map_j;
	wire [3:0] map_a;
	wire [3:0] map_b;
	wire indexed;
	wire indirect;
	wire [WW-1:0] ea;

	// one decode shared by the sequencer and the flag logic
	function special_dispatch_select_is;
		input [SPW-1:0] sel;
		input [SPW-1:0] code;
		begin
			special_dispatch_select_is = (sel == code);
		end
	endfunction

	assign map_wr = reg_wr && (reg_addr == `MSD_REG_MAP_DATA);
	assign map_j = map_word[`MSD_MAP_J_HI:`MSD_MAP_J_LO];
	assign map_a = map_word[`MSD_MAP_A_HI:`MSD_MAP_A_LO];
	assign map_b = map_word[`MSD_MAP_B_HI:`MSD_MAP_B_LO];
	assign index_select = instruction_hold_register_ff[`MSD_INSTR_INDEX_HI:`MSD_INSTR_INDEX_LO];
	assign indexed = |index_select;
	assign indirect = instruction_hold_register_ff[`MSD_INSTR_INDIRECT];

	// map read follows the held opcode, so it is ready one cycle after a load
	msd_map_mem #(
		.AW(OPW),
		.DW(`MSD_MAP_W)
	) u_map (
		.clk_sys(clk_sys),
		.wr_en(map_wr),
		.wr_addr(map_addr_ff),
		.wr_data(reg_wdata[`MSD_MAP_W-1:0]),
		.rd_addr(instruction_hold_register_ff[`MSD_INSTR_OP_HI:`MSD_INSTR_OP_LO]),
		.rd_data(map_word)
	);

	msd_ea_adder #(
		.W(WW)
	) u_ea (
		.clk_sys(clk_sys),
		.rst(rst),
		.indexed(indexed),
		.arith(arith_ff),
		.index_data(index_register),
		.ea_ff(ea)
	);

	// next microaddress selection
	always @*
	begin
		nxt_upc = uword_jump;
		if (upc_ff == `MSD_UA_NEXT)
		begin
			// decision matrix: trap wins over normal instruction entry
			if (trap_pending)
				nxt_upc = `MSD_UA_NEXT | `MSD_NI_OFS_TRAP;
			else if (next_instruction_condition)
				nxt_upc = `MSD_UA_NEXT | `MSD_NI_OFS_NORMAL;
			else
				nxt_upc = `MSD_UA_NEXT;
		end
		else if (special_dispatch_select_is(special_dispatch_select, `MSD_SPECIAL_DISPATCH_SELECT_ADDR_MODE))
			nxt_upc = uword_jump | {{(UAW-2){1'b0}}, indirect, indexed};
		else if (special_dispatch_select_is(special_dispatch_select, `MSD_SPECIAL_DISPATCH_SELECT_STORE))
			nxt_upc = uword_jump | {{(UAW-4){1'b0}}, map_b};
		else if (special_dispatch_select_is(special_dispatch_select, `MSD_SPECIAL_DISPATCH_SELECT_NEXT_INSTR))
			nxt_upc = uword_jump;
		else if (special_dispatch_select_is(special_dispatch_select, `MSD_SPECIAL_DISPATCH_SELECT_OPERAND_READ))
			nxt_upc = (compute_address_flag_ff ? `MSD_UA_OPERAND_BASE : uword_jump) | {{(UAW-4){1'b0}}, map_a};
		else if (special_dispatch_select_is(special_dispatch_select, `MSD_SPECIAL_DISPATCH_SELECT_MAP_JUMP))
			nxt_upc = map_j;
		if (!run_ff)
			nxt_upc = upc_ff;
	end

	// address computation flag and arithmetic register
	always @*
	begin
		nxt_compute_address_flag = compute_address_flag_ff;
		nxt_arith = arith_ff;
		// microword fields mean nothing while the decision address is current
		if (run_ff && upc_ff != `MSD_UA_NEXT)
		begin
			if (upc_ff == `MSD_UA_EXEC_ENTRY)
			begin
				// sign extend the y field of the held instruction
				nxt_arith = {{(WW-18){instruction_hold_register_ff[`MSD_INSTR_Y_HI]}},
					instruction_hold_register_ff[`MSD_INSTR_Y_HI:0]};
			end
			if (special_dispatch_select_is(special_dispatch_select, `MSD_SPECIAL_DISPATCH_SELECT_ADDR_MODE))
				nxt_compute_address_flag = 1'b1;
			else if (special_dispatch_select_is(special_dispatch_select, `MSD_SPECIAL_DISPATCH_SELECT_OPERAND_READ))
			begin
				nxt_compute_address_flag = 1'b0;
				nxt_arith = ea;
			end
			else if (special_dispatch_select_is(special_dispatch_select, `MSD_SPECIAL_DISPATCH_SELECT_NEXT_INSTR))
				nxt_compute_address_flag = 1'b0;
		end
	end

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			upc_ff <= `MSD_UA_NEXT;
			arith_ff <= {WW{1'b0}};
			compute_address_flag_ff <= 1'b0;
			instruction_hold_register_ff <= {WW{1'b0}};
		end
		else
		begin
			upc_ff <= nxt_upc;
			arith_ff <= nxt_arith;
			compute_address_flag_ff <= nxt_compute_address_flag;
			// prefetch lands here; execution reads only the held copy
			if (fetch_valid)
				instruction_hold_register_ff <= fetch_data;
		end
	end

	// register port
	always @*
	begin
		nxt_rdata = 32'h00000000;
		case (reg_addr)
			`MSD_REG_CTRL:
				nxt_rdata = {31'h00000000, run_ff};
			`MSD_REG_MAP_ADDR:
				nxt_rdata = {{(32-OPW){1'b0}}, map_addr_ff};
			`MSD_REG_STATUS:
				nxt_rdata = {{(32-UAW-1){1'b0}}, compute_address_flag_ff, upc_ff};
			`MSD_REG_EA:
				nxt_rdata = ea[31:0];
			`MSD_REG_HOLD:
				nxt_rdata = instruction_hold_register_ff[31:0];
			default:
				nxt_rdata = 32'h00000000;
		endcase
	end

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			run_ff <= `MSD_CTRL_RESET;
			map_addr_ff <= {OPW{1'b0}};
			reg_rdata <= 32'h00000000;
		end
		else
		begin
			reg_rdata <= reg_rd ? nxt_rdata : 32'h00000000;
			if (reg_wr && reg_addr == `MSD_REG_CTRL)
				run_ff <= reg_wdata[`MSD_CTRL_RUN];
			// auto-increment lets software stream the whole map
			if (reg_wr && reg_addr == `MSD_REG_MAP_ADDR)
				map_addr_ff <= reg_wdata[OPW-1:0];
			else if (map_wr)
				map_addr_ff <= map_addr_ff + {{(OPW-1){1'b0}}, 1'b1};
		end
	end

	assign next_microaddress = upc_ff;
	assign effective_address = ea;
	assign arithmetic_register = arith_ff;
	assign compute_address_flag = compute_address_flag_ff;
endmodule
`default_nettype wire
